// ===== rtl/led_pwm_output_stage.sv
// LED output stage: per-channel PWM, group dim/blink, polarity and drive mapping, APB slave
`include "led_pwm_cfg.svh"
module led_pwm_output_stage #(
  parameter int CHANNELS = 8,
  parameter int IND_STEP = `IND_STEP_CYCLES,
  parameter int DIM_STEP = `DIM_STEP_CYCLES,
  parameter int BLINK_STEP = `BLINK_STEP_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic output_gate_n,
  output logic [CHANNELS-1:0] channel_output_pin_o,
  output logic [CHANNELS-1:0] channel_output_pin_oe
);
  localparam int SW = (IND_STEP > DIM_STEP) ? ((IND_STEP > BLINK_STEP) ? IND_STEP : BLINK_STEP) :
                      ((DIM_STEP > BLINK_STEP) ? DIM_STEP : BLINK_STEP);
  localparam int PW = $clog2(SW + 1);

  typedef struct packed {
    led_pwm_pkg::mode_type mode;
    logic [CHANNELS-1:0][1:0] channel_state_select;
    logic [CHANNELS-1:0][7:0] individual_duty_value;
    logic [7:0] group_duty_value;
    logic [7:0] group_period;
    logic [PW-1:0] ind_pre;
    logic [7:0] ind_cnt;
    logic [PW-1:0] grp_pre;
    logic [7:0] grp_sub;
    logic [7:0] grp_cnt;
    logic [CHANNELS-1:0] pin_o;
    logic [CHANNELS-1:0] pin_oe;
    led_pwm_pkg::apb_resp_type resp;
  } state_type;

  state_type state_reg;
  state_type state_next;

  // Pin level and enable for an active/inactive decision, in the enabled state
  function automatic logic [1:0] map_pin(input logic active, input logic totem);
    if (active) begin
      map_pin = 2'b01;
    end else if (totem) begin
      map_pin = 2'b11;
    end else begin
      map_pin = 2'b00;
    end
  endfunction

  // True while a counter sits below the duty value: value/256 of the period
  function automatic logic duty_on(input logic [7:0] cnt, input logic [7:0] duty);
    duty_on = cnt < duty;
  endfunction

  function automatic logic [PW-1:0] step_len(input logic blink);
    if (blink) begin
      step_len = PW'(BLINK_STEP - 1);
    end else begin
      step_len = PW'(DIM_STEP - 1);
    end
  endfunction

  function automatic logic duty_addr(input logic [7:0] a);
    logic low_ok;
    logic high_ok;
    low_ok = a >= `REG_DUTY_BASE;
    high_ok = a < (`REG_DUTY_BASE + 8'(4 * CHANNELS));
    duty_addr = low_ok && high_ok && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [4:0] duty_index(input logic [7:0] a);
    logic [7:0] rel;
    rel = a - `REG_DUTY_BASE;
    duty_index = rel[6:2];
  endfunction

  // Mapped words: mode, state, group and status, then one duty word per channel
  function automatic logic addr_mapped(input logic [7:0] a);
    logic fixed;
    logic duty;
    fixed = (a == `REG_MODE1) || (a == `REG_MODE2) || (a == `REG_STATE);
    fixed = fixed || (a == `REG_GRP_DUTY) || (a == `REG_GRP_FREQ) || (a == `REG_STATUS);
    duty = duty_addr(a);
    addr_mapped = fixed || duty;
  endfunction

  // Unmapped and unaligned offsets read as zero, so a refused read leaks nothing
  function automatic logic [31:0] read_word(input state_type s, input logic [7:0] a, input logic grp);
    logic [31:0] word;
    word = 32'h0000_0000;
    case (a)
      `REG_MODE1: begin
        word = {27'h0, s.mode.sleep, 4'h0};
      end
      `REG_MODE2: begin
        word = {26'h0, s.mode.group_dim_blink_select, s.mode.output_polarity_invert, 1'b0,
                s.mode.totem_pole_drive_select, s.mode.disabled_output_state};
      end
      `REG_STATE: begin
        word = 32'(s.channel_state_select);
      end
      `REG_GRP_DUTY: begin
        word = {24'h0, s.group_duty_value};
      end
      `REG_GRP_FREQ: begin
        word = {24'h0, s.group_period};
      end
      `REG_STATUS: begin
        word = {16'h0, 7'h0, grp, s.pin_o};
      end
      default: begin
        if (duty_addr(a)) begin
          word = {24'h0, s.individual_duty_value[duty_index(a)]};
        end
      end
    endcase
    read_word = word;
  endfunction

  // Pin pair of one channel from its state select, both PWM terms and the mode bits
  function automatic logic [1:0] chan_pin(input logic [1:0] sel, input logic ind, input logic grp,
                                          input logic invert, input logic totem);
    led_pwm_pkg::chan_state_type kind;
    logic active;
    kind = led_pwm_pkg::chan_state_type'(sel);
    active = 1'b0;
    case (kind)
      led_pwm_pkg::state_off: begin
        active = invert;
      end
      led_pwm_pkg::state_on: begin
        active = !invert;
      end
      led_pwm_pkg::state_individual: begin
        if (invert) begin
          active = !ind;
        end else begin
          active = ind;
        end
      end
      led_pwm_pkg::state_group: begin
        // Inverting both terms means low while either is inactive
        if (invert) begin
          active = !ind || !grp;
        end else begin
          active = ind && grp;
        end
      end
      default: begin
        active = 1'b0;
      end
    endcase
    chan_pin = map_pin(active, totem);
  endfunction

  // Disabled-state field while the gate is high; the reserved code floats
  function automatic logic [1:0] gated_pin(input logic [1:0] dis, input logic totem);
    logic [1:0] pair;
    case (dis)
      2'b00: pair = 2'b01;
      2'b01: pair = map_pin(1'b0, totem);
      default: pair = 2'b00;
    endcase
    gated_pin = pair;
  endfunction

  logic setup_write;
  logic access;
  logic ind_active;
  logic grp_active;
  logic inv;
  logic [1:0] pin;

  assign access = psel && penable;
  assign setup_write = access && pwrite;

  always_comb begin
    state_next = state_reg;
    ind_active = 1'b0;
    pin = 2'b00;
    grp_active = duty_on(state_reg.grp_cnt, state_reg.group_duty_value);
    inv = state_reg.mode.output_polarity_invert;

    // Register bus: one wait-free access phase, writes at the access edge
    state_next.resp.pready = 1'b0;
    state_next.resp.pslverr = 1'b0;
    state_next.resp.prdata = 32'h0000_0000;
    if (psel && !penable) begin
      state_next.resp.pready = 1'b1;
      state_next.resp.pslverr = 1'b1;
      if (addr_mapped(paddr)) begin
        state_next.resp.pslverr = 1'b0;
      end
      if (!pwrite) begin
        state_next.resp.prdata = read_word(state_reg, paddr, grp_active);
      end
    end

    if (setup_write && state_reg.resp.pready) begin
      case (paddr)
        `REG_MODE1: state_next.mode.sleep = pwdata[`MODE1_SLEEP_BIT];
        `REG_MODE2: begin
          state_next.mode.group_dim_blink_select = pwdata[`MODE2_BLINK_BIT];
          state_next.mode.output_polarity_invert = pwdata[`MODE2_INVERT_BIT];
          state_next.mode.totem_pole_drive_select = pwdata[`MODE2_TOTEM_BIT];
          state_next.mode.disabled_output_state = pwdata[`MODE2_DIS_LSB +: 2];
        end
        `REG_STATE: state_next.channel_state_select = pwdata[2*CHANNELS-1:0];
        `REG_GRP_DUTY: state_next.group_duty_value = pwdata[7:0];
        `REG_GRP_FREQ: state_next.group_period = pwdata[7:0];
        default: begin
          if (duty_addr(paddr)) begin
            state_next.individual_duty_value[duty_index(paddr)] = pwdata[7:0];
          end
        end
      endcase
    end

    // Oscillator gated by sleep: counters and pins hold, so nothing blinks or dims
    if (!state_reg.mode.sleep) begin
      if (state_reg.ind_pre == PW'(IND_STEP - 1)) begin
        state_next.ind_pre = '0;
        state_next.ind_cnt = state_reg.ind_cnt + 8'h01;
      end else begin
        state_next.ind_pre = state_reg.ind_pre + PW'(1);
      end
      // One shared group counter serves dim or blink, never both
      if (state_reg.grp_pre >= step_len(state_reg.mode.group_dim_blink_select)) begin
        state_next.grp_pre = '0;
        // Blink step lasts period+1 base steps: 24 Hz at 0, 10.67 s at 255
        if (!state_reg.mode.group_dim_blink_select || state_reg.grp_sub == state_reg.group_period) begin
          state_next.grp_sub = 8'h00;
          state_next.grp_cnt = state_reg.grp_cnt + 8'h01;
        end else begin
          state_next.grp_sub = state_reg.grp_sub + 8'h01;
        end
      end else begin
        state_next.grp_pre = state_reg.grp_pre + PW'(1);
      end

      for (int i = 0; i < CHANNELS; i++) begin
        ind_active = duty_on(state_reg.ind_cnt, state_reg.individual_duty_value[i]);
        pin = chan_pin(state_reg.channel_state_select[i], ind_active, grp_active, inv,
                       state_reg.mode.totem_pole_drive_select);
        // The gate overrides the whole mapping, polarity included
        if (output_gate_n) begin
          pin = gated_pin(state_reg.mode.disabled_output_state, state_reg.mode.totem_pole_drive_select);
        end
        state_next.pin_o[i] = pin[1];
        state_next.pin_oe[i] = pin[0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
      state_reg.mode.totem_pole_drive_select <= 1'b1;
      state_reg.group_duty_value <= `GRP_DUTY_RESET;
      state_reg.pin_o <= '1;
      state_reg.pin_oe <= '1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.resp.prdata;
  assign pready = state_reg.resp.pready;
  assign pslverr = state_reg.resp.pslverr;
  assign channel_output_pin_o = state_reg.pin_o;
  assign channel_output_pin_oe = state_reg.pin_oe;
endmodule

// ===== rtl/led_pwm_cfg.svh
// Offsets, field positions, reset values and timing counts of the LED output stage
`ifndef LED_PWM_CFG_SVH
`define LED_PWM_CFG_SVH
`define REG_MODE1 8'h00
`define REG_MODE2 8'h04
`define REG_STATE 8'h08
`define REG_GRP_DUTY 8'h0c
`define REG_GRP_FREQ 8'h10
`define REG_STATUS 8'h14
`define REG_DUTY_BASE 8'h20
`define MODE1_SLEEP_BIT 4
`define MODE2_BLINK_BIT 5
`define MODE2_INVERT_BIT 4
`define MODE2_TOTEM_BIT 2
`define MODE2_DIS_LSB 0
`define MODE1_RESET 8'h00
`define MODE2_RESET 8'h04
`define GRP_DUTY_RESET 8'hff
`define GRP_FREQ_RESET 8'h00
`define CLK_HZ 40000000
`define IND_PWM_HZ 97000
`define GRP_DIM_HZ 190
`define BLINK_MAX_HZ 24
// Cycles per individual PWM step: 256 steps per period, rounded down
`define IND_STEP_CYCLES ((`CLK_HZ / `IND_PWM_HZ) / 256)
`define DIM_STEP_CYCLES ((`CLK_HZ / `GRP_DIM_HZ) / 256)
`define BLINK_STEP_CYCLES ((`CLK_HZ / `BLINK_MAX_HZ) / 256)
`endif

// ===== rtl/led_pwm_pkg.sv
// Types shared by the LED output stage
package led_pwm_pkg;
  typedef enum logic [1:0] {
    state_off,
    state_on,
    state_individual,
    state_group
  } chan_state_type;

  typedef struct packed {
    logic sleep;
    logic group_dim_blink_select;
    logic output_polarity_invert;
    logic totem_pole_drive_select;
    logic [1:0] disabled_output_state;
  } mode_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_resp_type;
endpackage

// ===== verification/led_load.sv
// Load model on the LED pins: pull-up resistor to the supply
module led_load (
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe,
  output logic [7:0] level
);
  timeunit 1ns;
  timeprecision 1ps;
  // A released pin is pulled high, never left at its last driven value
  assign level = (pin_o & pin_oe) | ~pin_oe;
endmodule

// ===== verification/led_pwm_output_stage_properties.sv
// Port checks of the LED output stage
module led_pwm_output_stage_checker #(
  parameter int CHANNELS = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic output_gate_n,
  input wire logic [CHANNELS-1:0] channel_output_pin_o,
  input wire logic [CHANNELS-1:0] channel_output_pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] m1_reg;
  logic [7:0] m2_reg;
  logic [15:0] st_reg;
  logic mapped;
  logic calm;
  assign mapped = paddr[1:0] == 2'b00 && (paddr <= 8'h14 || (paddr >= 8'h20 && paddr <= 8'h3c));
  assign calm = !m1_reg[4] && !output_gate_n;
  // Shadow copies follow completed writes only, as the slave does
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m1_reg <= 8'h00;
      m2_reg <= 8'h04;
      st_reg <= 16'h0000;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == 8'h00) m1_reg <= pwdata[7:0];
      if (paddr == 8'h04) m2_reg <= pwdata[7:0];
      if (paddr == 8'h08) st_reg <= pwdata[15:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_ready_acc; pready |-> psel && penable; endproperty
  a_ready_acc: assert property (p_ready_acc) else $error("ready outside access");
  property p_err; pready && !mapped |-> pslverr && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_ok; pready && mapped |-> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("mapped access refused");
  property p_reset; $rose(presetn) |-> &channel_output_pin_o && &channel_output_pin_oe; endproperty
  a_reset: assert property (p_reset) else $error("pins not high after reset");
  // Three samples leave room for the register stages between setting and pin
  property p_off; (calm && st_reg == 16'h0 && !m2_reg[4] && m2_reg[2])[*3] |-> &channel_output_pin_o; endproperty
  a_off: assert property (p_off) else $error("off totem pin not high");
  property p_on; (calm && st_reg == 16'h5555 && !m2_reg[4])[*3] |-> channel_output_pin_o == '0; endproperty
  a_on: assert property (p_on) else $error("on pin not low");
  property p_gate_low; (!m1_reg[4] && output_gate_n && m2_reg[1:0] == 2'b00)[*3] |-> &channel_output_pin_oe; endproperty
  a_gate_low: assert property (p_gate_low) else $error("gated pin not driven");
  property p_gate_float; (!m1_reg[4] && output_gate_n && m2_reg[1])[*3] |-> channel_output_pin_oe == '0; endproperty
  a_gate_float: assert property (p_gate_float) else $error("gated pin not released");
  property p_sleep; m1_reg[4][*3] |-> $stable(channel_output_pin_o) && $stable(channel_output_pin_oe); endproperty
  a_sleep: assert property (p_sleep) else $error("pins move while asleep");
endmodule

bind led_pwm_output_stage led_pwm_output_stage_checker #(.CHANNELS(CHANNELS)) checker_inst (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .output_gate_n,
  .channel_output_pin_o, .channel_output_pin_oe);

// ===== verification/tb.sv
// Register-level testbench of the LED output stage
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic output_gate_n = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] pin_o;
  logic [7:0] pin_oe;
  logic [7:0] level;
  logic [31:0] rd;
  logic err;
  logic inv;
  logic tot;
  logic lo;
  logic [1:0] dis;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int low;
  int run;
  int duty[3] = '{0, 64, 255};
  always #12.5 pclk = ~pclk;
  // Short group steps keep the slow group waveforms inside a brief run
  led_pwm_output_stage #(.DIM_STEP(2), .BLINK_STEP(4)) led_pwm_output_stage_inst (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .output_gate_n,
    .channel_output_pin_o(pin_o), .channel_output_pin_oe(pin_oe));
  led_load led_load_inst (.pin_o(pin_o), .pin_oe(pin_oe), .level(level));
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      $display("[FAIL] %0t run too long", $time);
      close_out;
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    if (n == 16) check(1'b0, 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Low cycles and longest high stretch of channel 0 over n cycles
  task meas(input int n);
    int h;
    h = 0;
    low = 0;
    run = 0;
    repeat (n) begin
      @(posedge pclk);
      if (level[0] === 1'b0) begin
        low++;
        h = 0;
      end else begin
        h++;
        if (h > run) run = h;
      end
    end
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check({pin_oe, level}, 16'hffff);
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h4);
    apb(1'b0, 8'h0c, 32'h0);
    check(rd, 32'hff);
    apb(1'b0, 8'h18, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    $display("test reset and map done");
    for (int c = 0; c < 8; c++) begin
      inv = c[1];
      tot = c[2];
      lo = c[0] ^ inv;
      apb(1'b1, 8'h04, {24'h0, 3'b000, inv, 1'b0, tot, 2'b00});
      apb(1'b1, 8'h08, c[0] ? 32'h5555 : 32'h0);
      repeat (4) @(posedge pclk);
      check({pin_oe, level}, {{8{lo | tot}}, {8{!lo}}});
    end
    $display("test static states done");
    apb(1'b1, 8'h08, 32'haaaa);
    for (int c = 0; c < 6; c++) begin
      apb(1'b1, 8'h04, {24'h0, 3'b000, c[0], 4'b0100});
      apb(1'b1, 8'h20, duty[c / 2]);
      repeat (4) @(posedge pclk);
      meas(256);
      check(low, c[0] ? 256 - duty[c / 2] : duty[c / 2]);
    end
    $display("test individual pwm done");
    apb(1'b1, 8'h04, 32'h4);
    apb(1'b1, 8'h20, 32'd64);
    apb(1'b1, 8'h00, 32'h10);
    repeat (4) @(posedge pclk);
    meas(300);
    check(low == 0 || low == 300, 1'b1);
    apb(1'b1, 8'h00, 32'h0);
    repeat (4) @(posedge pclk);
    meas(256);
    check(low, 32'd64);
    $display("test sleep done");
    output_gate_n <= 1'b1;
    for (int c = 0; c < 6; c++) begin
      dis = 2'(c / 2);
      apb(1'b1, 8'h04, {24'h0, 5'b00000, c[0], dis});
      repeat (4) @(posedge pclk);
      check({pin_oe, level}, {{8{dis == 2'b00 || (dis == 2'b01 && c[0])}}, {8{dis != 2'b00}}});
    end
    output_gate_n <= 1'b0;
    $display("test output gate done");
    apb(1'b1, 8'h08, 32'hffff);
    apb(1'b1, 8'h0c, 32'h80);
    apb(1'b1, 8'h04, 32'h4);
    repeat (4) @(posedge pclk);
    meas(512);
    check(low, 32'd64);
    apb(1'b1, 8'h04, 32'h14);
    repeat (4) @(posedge pclk);
    meas(512);
    check(low, 32'd448);
    apb(1'b1, 8'h20, 32'd255);
    for (int c = 0; c < 3; c++) begin
      apb(1'b1, 8'h10, c == 2);
      apb(1'b1, 8'h04, {24'h0, 2'b00, c != 0, 5'b00100});
      repeat (4) @(posedge pclk);
      meas(1024 << c);
      check(run >= (256 << c) && run <= (256 << c) + 1, 1'b1);
    end
    $display("test group dim and blink done");
    close_out;
  end
endmodule
